// >>> src/mfcfg_pkg.sv
`default_nettype none
package mfcfg_pkg;
    localparam logic [11:0] ADDR_RECEIVE_CONFIGURATION  = 12'h06C;
    localparam logic [11:0] ADDR_TRANSMIT_CONFIGURATION = 12'h070;
    localparam logic [11:0] ADDR_IRQ_STATUS = 12'h080;
    localparam logic [11:0] ADDR_IRQ_ENABLE = 12'h084;
    localparam logic [11:0] ADDR_IRQ_CLEAR  = 12'h088;

    localparam int RX_END_ALIGN_HI  = 31;
    localparam int RX_END_ALIGN_LO  = 30;
    localparam int RX_FLUSH_BIT     = 15;
    localparam int RX_PAD_HI        = 12;
    localparam int RX_PAD_LO        = 8;
    localparam int TX_STAT_FLUSH_BIT = 15;
    localparam int TX_DATA_FLUSH_BIT = 14;
    localparam int TX_OVR_ALLOW_BIT = 2;
    localparam int TX_ENABLE_BIT    = 1;
    localparam int TX_STOP_BIT      = 0;

    localparam int IRQ_BITS         = 4;
    localparam int IRQ_RX_FLUSHED   = 0;
    localparam int IRQ_TXS_FLUSHED  = 1;
    localparam int IRQ_TXD_FLUSHED  = 2;
    localparam int IRQ_TX_STOPPED   = 3;

    localparam logic [1:0] ALIGN_CODE_4  = 2'h0;
    localparam logic [1:0] ALIGN_CODE_16 = 2'h1;
    localparam logic [1:0] ALIGN_CODE_32 = 2'h2;
    localparam logic [5:0] ALIGN_BYTES_4  = 6'h04;
    localparam logic [5:0] ALIGN_BYTES_16 = 6'h10;
    localparam logic [5:0] ALIGN_BYTES_32 = 6'h20;

    typedef struct packed {
        logic       rx_flush;
        logic       tx_status_flush;
        logic       tx_data_flush;
        logic [4:0] rx_lead_pad_bytes;
        logic [5:0] rx_end_align_bytes;
        logic       rx_end_align_bad;
        logic       tx_run;
    } mfcfg_ctrl_t;
endpackage : mfcfg_pkg
`default_nettype wire

// >>> src/mfcfg_align_dec.sv
`default_nettype none
module mfcfg_align_dec (
    input  wire logic [1:0] code_in,
    output logic      [5:0] bytes_out,
    output logic            reserved_out
);
    always_comb begin
        reserved_out = 1'b0;
        unique case (code_in)
            mfcfg_pkg::ALIGN_CODE_4:  bytes_out = mfcfg_pkg::ALIGN_BYTES_4;
            mfcfg_pkg::ALIGN_CODE_16: bytes_out = mfcfg_pkg::ALIGN_BYTES_16;
            mfcfg_pkg::ALIGN_CODE_32: bytes_out = mfcfg_pkg::ALIGN_BYTES_32;
            default: begin
                // The reserved code falls back to DWORD alignment so padding stays bounded.
                bytes_out    = mfcfg_pkg::ALIGN_BYTES_4;
                reserved_out = 1'b1;
            end
        endcase
    end
endmodule : mfcfg_align_dec
`default_nettype wire

// >>> src/mfcfg_top.sv
// What this block does
// - Receive flush write empties RX data and status FIFO pointers, then self-clears.
// - Leading pad byte count 0..31 is driven to the receive datapath.
// - Upper three pad bits may change live; datapath applies at next DWORD read.
// - End alignment code: 00 four, 01 sixteen, 10 thirty-two bytes, 11 reserved.
// - Transmit status flush write empties TX status FIFO pointers, then self-clears.
// - Transmit data flush write empties TX data FIFO pointers, then self-clears.
// - Without overrun allowance, transmission pauses while TX status FIFO is full.
// - Overrun allowance never affects the status FIFO full interrupt.
// - Transmitter enable set makes the transmitter run and send queued data.
// - Enable clears itself once a stop was requested and the transmitter halted.
// - Stop request finishes the current frame, then stops; request clears afterwards.
// - Host writes to the stop bit are ignored while it is set.
// - Final receive transfer is padded to end alignment; host discards padding.
//
// Chosen here: the APB register port.
`default_nettype none
module mfcfg_top (
    input  wire logic                  ref_clk_in,
    input  wire logic                  rst_in,
    input  wire logic                  psel_in,
    input  wire logic                  penable_in,
    input  wire logic                  pwrite_in,
    input  wire logic [11:0]           paddr_in,
    input  wire logic [31:0]           pwdata_in,
    input  wire logic [3:0]            pstrb_in,
    output logic      [31:0]           prdata_out,
    output logic                       pready_out,
    output logic                       pslverr_out,
    input  wire logic                  tx_status_full_in,
    input  wire logic                  tx_frame_active_in,
    input  wire logic                  tx_status_full_irq_in,
    output mfcfg_pkg::mfcfg_ctrl_t     ctrl_out,
    output logic                       tx_status_full_irq_out,
    output logic                       irq_out
);
    logic [1:0]  rx_end_align;
    logic        rx_flush;
    logic [4:0]  rx_lead_pad_bytes;
    logic        tx_status_flush;
    logic        tx_data_flush;
    logic        tx_status_overrun_allow;
    logic        tx_enable;
    logic        tx_stop_req;
    logic [mfcfg_pkg::IRQ_BITS-1:0] irq_status;
    logic [mfcfg_pkg::IRQ_BITS-1:0] irq_enable;
    logic [mfcfg_pkg::IRQ_BITS-1:0] irq_event;
    logic [mfcfg_pkg::IRQ_BITS-1:0] irq_clear;
    logic [5:0]  align_bytes;
    logic        align_bad;
    logic        tx_halted;
    logic        wr_access;
    logic        rd_access;
    logic        addr_hit;
    logic        wr_rx;
    logic        wr_tx;
    logic [31:0] receive_configuration_view;
    logic [31:0] transmit_configuration_view;
    logic        hit_receive;
    logic        hit_transmit;
    logic        hit_irq_status;
    logic        hit_irq_enable;
    logic        hit_irq_clear;
    logic        lane_align;
    logic        lane_pad;
    logic        lane_rx_flush;
    logic        lane_txs_flush;
    logic        lane_txd_flush;
    logic        lane_tx_ctrl;
    logic        lane_irq;
    logic [31:0] next_prdata;

    mfcfg_align_dec u_align (
        .code_in      (rx_end_align),
        .bytes_out    (align_bytes),
        .reserved_out (align_bad)
    );

    // Single-cycle access phase: the slave never inserts wait states.
    assign pready_out = 1'b1;
    assign wr_access  = psel_in & penable_in & pwrite_in;
    assign rd_access  = psel_in & ~penable_in & ~pwrite_in;
    assign hit_receive    = (paddr_in == mfcfg_pkg::ADDR_RECEIVE_CONFIGURATION);
    assign hit_transmit   = (paddr_in == mfcfg_pkg::ADDR_TRANSMIT_CONFIGURATION);
    assign hit_irq_status = (paddr_in == mfcfg_pkg::ADDR_IRQ_STATUS);
    assign hit_irq_enable = (paddr_in == mfcfg_pkg::ADDR_IRQ_ENABLE);
    assign hit_irq_clear  = (paddr_in == mfcfg_pkg::ADDR_IRQ_CLEAR);
    assign addr_hit    = hit_receive | hit_transmit | hit_irq_status | hit_irq_enable | hit_irq_clear;
    assign pslverr_out = psel_in & penable_in & ~addr_hit;
    assign wr_rx = wr_access & hit_receive;
    assign wr_tx = wr_access & hit_transmit;

    // Byte lanes follow the field positions, so a moved field keeps its strobe, except stop and overrun allow, which take the enable bit's lane.
    assign lane_align     = pstrb_in[mfcfg_pkg::RX_END_ALIGN_HI / 8];
    assign lane_pad       = pstrb_in[mfcfg_pkg::RX_PAD_HI / 8];
    assign lane_rx_flush  = pstrb_in[mfcfg_pkg::RX_FLUSH_BIT / 8];
    assign lane_txs_flush = pstrb_in[mfcfg_pkg::TX_STAT_FLUSH_BIT / 8];
    assign lane_txd_flush = pstrb_in[mfcfg_pkg::TX_DATA_FLUSH_BIT / 8];
    assign lane_tx_ctrl   = pstrb_in[mfcfg_pkg::TX_ENABLE_BIT / 8];
    assign lane_irq       = pstrb_in[(mfcfg_pkg::IRQ_BITS - 1) / 8];

    // The transmitter counts as halted once a stop is pending and no frame is on the wire.
    assign tx_halted = tx_stop_req & ~tx_frame_active_in;

    always_ff @(posedge ref_clk_in or posedge rst_in) begin
        if (rst_in) begin
            rx_end_align      <= 2'h0;
            rx_lead_pad_bytes <= 5'h00;
        end else if (wr_rx) begin
            if (lane_align) begin
                rx_end_align <= pwdata_in[mfcfg_pkg::RX_END_ALIGN_HI:mfcfg_pkg::RX_END_ALIGN_LO];
            end
            if (lane_pad) begin
                rx_lead_pad_bytes <= pwdata_in[mfcfg_pkg::RX_PAD_HI:mfcfg_pkg::RX_PAD_LO];
            end
        end
    end

    // Flush strobes are one-cycle pulses; they read back as zero once the pointers have been cleared.
    always_ff @(posedge ref_clk_in or posedge rst_in) begin
        if (rst_in) begin
            rx_flush        <= 1'b0;
            tx_status_flush <= 1'b0;
            tx_data_flush   <= 1'b0;
        end else begin
            rx_flush        <= wr_rx & lane_rx_flush & pwdata_in[mfcfg_pkg::RX_FLUSH_BIT];
            tx_status_flush <= wr_tx & lane_txs_flush & pwdata_in[mfcfg_pkg::TX_STAT_FLUSH_BIT];
            tx_data_flush   <= wr_tx & lane_txd_flush & pwdata_in[mfcfg_pkg::TX_DATA_FLUSH_BIT];
        end
    end

    always_ff @(posedge ref_clk_in or posedge rst_in) begin
        if (rst_in) begin
            tx_status_overrun_allow <= 1'b0;
        end else if (wr_tx & lane_tx_ctrl) begin
            tx_status_overrun_allow <= pwdata_in[mfcfg_pkg::TX_OVR_ALLOW_BIT];
        end
    end

    // A halt clears enable even if the same cycle carries a host write, so the stop always lands.
    always_ff @(posedge ref_clk_in or posedge rst_in) begin
        if (rst_in) begin
            tx_enable <= 1'b0;
        end else if (tx_halted) begin
            tx_enable <= 1'b0;
        end else if (wr_tx & lane_tx_ctrl) begin
            tx_enable <= pwdata_in[mfcfg_pkg::TX_ENABLE_BIT];
        end
    end

    always_ff @(posedge ref_clk_in or posedge rst_in) begin
        if (rst_in) begin
            tx_stop_req <= 1'b0;
        end else if (tx_stop_req) begin
            if (tx_halted) begin
                tx_stop_req <= 1'b0;
            end
        end else if (wr_tx & lane_tx_ctrl) begin
            tx_stop_req <= pwdata_in[mfcfg_pkg::TX_STOP_BIT];
        end
    end

    assign irq_event[mfcfg_pkg::IRQ_RX_FLUSHED]  = rx_flush;
    assign irq_event[mfcfg_pkg::IRQ_TXS_FLUSHED] = tx_status_flush;
    assign irq_event[mfcfg_pkg::IRQ_TXD_FLUSHED] = tx_data_flush;
    assign irq_event[mfcfg_pkg::IRQ_TX_STOPPED]  = tx_halted;
    assign irq_clear = (wr_access & hit_irq_clear & lane_irq) ?
                       pwdata_in[mfcfg_pkg::IRQ_BITS-1:0] : '0;

    genvar gi;
    generate
        for (gi = 0; gi < mfcfg_pkg::IRQ_BITS; gi++) begin : g_irq
            // A new event outranks a clear written in the same cycle.
            always_ff @(posedge ref_clk_in or posedge rst_in) begin
                if (rst_in) begin
                    irq_status[gi] <= 1'b0;
                end else if (irq_event[gi]) begin
                    irq_status[gi] <= 1'b1;
                end else if (irq_clear[gi]) begin
                    irq_status[gi] <= 1'b0;
                end
            end
        end
    endgenerate

    always_ff @(posedge ref_clk_in or posedge rst_in) begin
        if (rst_in) begin
            irq_enable <= '0;
        end else if (wr_access & hit_irq_enable & lane_irq) begin
            irq_enable <= pwdata_in[mfcfg_pkg::IRQ_BITS-1:0];
        end
    end

    assign irq_out = |(irq_status & irq_enable);

    always_comb begin
        receive_configuration_view = '0;
        receive_configuration_view[mfcfg_pkg::RX_END_ALIGN_HI:mfcfg_pkg::RX_END_ALIGN_LO] = rx_end_align;
        receive_configuration_view[mfcfg_pkg::RX_FLUSH_BIT] = rx_flush;
        receive_configuration_view[mfcfg_pkg::RX_PAD_HI:mfcfg_pkg::RX_PAD_LO] = rx_lead_pad_bytes;
        transmit_configuration_view = '0;
        transmit_configuration_view[mfcfg_pkg::TX_STAT_FLUSH_BIT] = tx_status_flush;
        transmit_configuration_view[mfcfg_pkg::TX_DATA_FLUSH_BIT] = tx_data_flush;
        transmit_configuration_view[mfcfg_pkg::TX_OVR_ALLOW_BIT]  = tx_status_overrun_allow;
        transmit_configuration_view[mfcfg_pkg::TX_ENABLE_BIT]     = tx_enable;
        transmit_configuration_view[mfcfg_pkg::TX_STOP_BIT]       = tx_stop_req;
        next_prdata = '0;
        unique case (paddr_in)
            mfcfg_pkg::ADDR_RECEIVE_CONFIGURATION:  next_prdata = receive_configuration_view;
            mfcfg_pkg::ADDR_TRANSMIT_CONFIGURATION: next_prdata = transmit_configuration_view;
            mfcfg_pkg::ADDR_IRQ_STATUS:             next_prdata[mfcfg_pkg::IRQ_BITS-1:0] = irq_status;
            mfcfg_pkg::ADDR_IRQ_ENABLE:             next_prdata[mfcfg_pkg::IRQ_BITS-1:0] = irq_enable;
            default:                                next_prdata = '0;
        endcase
    end

    // Read data is captured in the setup cycle so it is stable from a flop during the access phase.
    always_ff @(posedge ref_clk_in or posedge rst_in) begin
        if (rst_in) begin
            prdata_out <= '0;
        end else if (rd_access) begin
            prdata_out <= next_prdata;
        end
    end

    always_comb begin
        ctrl_out.rx_flush           = rx_flush;
        ctrl_out.tx_status_flush    = tx_status_flush;
        ctrl_out.tx_data_flush      = tx_data_flush;
        ctrl_out.rx_lead_pad_bytes  = rx_lead_pad_bytes;
        ctrl_out.rx_end_align_bytes = align_bytes;
        ctrl_out.rx_end_align_bad   = align_bad;
        // A pending stop still lets the current frame finish; the datapath starts no new frame then.
        ctrl_out.tx_run = tx_enable & ~(tx_stop_req & ~tx_frame_active_in) &
                          (tx_status_overrun_allow | ~tx_status_full_in);
    end

    // The full interrupt passes straight through, independent of the overrun allowance.
    assign tx_status_full_irq_out = tx_status_full_irq_in;
endmodule : mfcfg_top
`default_nettype wire

// >>> tb/mfcfg_far_model.sv
`default_nettype none
module mfcfg_far_model (
    input  wire logic clk_in,
    input  wire logic rst_in,
    input  wire logic run_in,
    input  wire logic full_req_in,
    output logic      active_out,
    output logic      full_out,
    output logic      full_irq_out
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [4:0] cnt;
    // A started frame runs to its end even if run drops, so a stop must wait for it.
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) cnt <= 5'h00;
        else if (cnt != 5'h00) cnt <= cnt - 5'h01;
        else if (run_in) cnt <= 5'h14;
    end
    assign active_out = (cnt != 5'h00);
    assign full_out = full_req_in;
    assign full_irq_out = full_req_in;
endmodule : mfcfg_far_model
`default_nettype wire

// >>> tb/mfcfg_monitor.sv
`default_nettype none
module mfcfg_monitor (
    input wire logic                   ref_clk_in,
    input wire logic                   rst_in,
    input wire logic                   psel_in,
    input wire logic                   penable_in,
    input wire logic                   pwrite_in,
    input wire logic [11:0]            paddr_in,
    input wire logic [31:0]            pwdata_in,
    input wire logic [3:0]             pstrb_in,
    input wire logic                   tx_status_full_in,
    input wire logic                   tx_status_full_irq_in,
    input wire logic                   tx_status_full_irq_out,
    input wire mfcfg_pkg::mfcfg_ctrl_t ctrl_out
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking cb @(posedge ref_clk_in); endclocking
    default disable iff (rst_in);
    logic wrx, wtx, allow;
    assign wrx = psel_in && penable_in && pwrite_in && paddr_in == mfcfg_pkg::ADDR_RECEIVE_CONFIGURATION;
    assign wtx = psel_in && penable_in && pwrite_in && paddr_in == mfcfg_pkg::ADDR_TRANSMIT_CONFIGURATION;
    always_ff @(posedge ref_clk_in or posedge rst_in) begin
        if (rst_in) allow <= 1'b0;
        else if (wtx && pstrb_in[0]) allow <= pwdata_in[2];
    end
    a_rx_flush_clear: assert property (ctrl_out.rx_flush |=> !ctrl_out.rx_flush)
        else $error("rx flush stuck");
    a_rx_flush_cause: assert property ($rose(ctrl_out.rx_flush) |-> $past(wrx && pwdata_in[15]))
        else $error("rx flush without write");
    a_txs_flush_pulse: assert property (
        ctrl_out.tx_status_flush |-> $past(wtx && pwdata_in[15]) ##1 !ctrl_out.tx_status_flush)
        else $error("tx status flush bad");
    a_txd_flush_pulse: assert property (
        ctrl_out.tx_data_flush |-> $past(wtx && pwdata_in[14]) ##1 !ctrl_out.tx_data_flush)
        else $error("tx data flush bad");
    a_full_suspend: assert property (tx_status_full_in && !allow |-> !ctrl_out.tx_run)
        else $error("runs while status full");
    a_full_irq_pass: assert property (tx_status_full_irq_out == tx_status_full_irq_in)
        else $error("full irq altered");
    a_pad_load: assert property (wrx && pstrb_in[1] |=>
        ctrl_out.rx_lead_pad_bytes == $past(pwdata_in[12:8])) else $error("pad not loaded");
    a_align_bad: assert property (wrx && pstrb_in[3] |=>
        ctrl_out.rx_end_align_bad == ($past(pwdata_in[31:30]) == 2'h3)) else $error("align flag");
    c_rx_flush: cover property (ctrl_out.rx_flush);
    c_txd_flush: cover property (ctrl_out.tx_data_flush);
    c_overrun: cover property (tx_status_full_in && allow && ctrl_out.tx_run);
endmodule : mfcfg_monitor
bind mfcfg_top mfcfg_monitor u_mfcfg_monitor (.ref_clk_in(ref_clk_in), .rst_in(rst_in), .psel_in(psel_in),
    .penable_in(penable_in), .pwrite_in(pwrite_in), .paddr_in(paddr_in), .pwdata_in(pwdata_in),
    .pstrb_in(pstrb_in), .tx_status_full_in(tx_status_full_in), .tx_status_full_irq_in(tx_status_full_irq_in),
    .tx_status_full_irq_out(tx_status_full_irq_out), .ctrl_out(ctrl_out));
`default_nettype wire

// >>> tb/tb.sv
`default_nettype none
module tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk, rst, psel, pen, pwr, full_req, pready, pslverr, tsf, act, firq_in, firq_out, irq, er;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [3:0] pstrb;
    mfcfg_pkg::mfcfg_ctrl_t ctrl;
    int mismatches, n_checks, cyc;
    mfcfg_top u_mfcfg_top (.ref_clk_in(clk), .rst_in(rst), .psel_in(psel), .penable_in(pen), .pwrite_in(pwr),
        .paddr_in(paddr), .pwdata_in(pwdata), .pstrb_in(pstrb), .prdata_out(prdata), .pready_out(pready),
        .pslverr_out(pslverr), .tx_status_full_in(tsf), .tx_frame_active_in(act), .tx_status_full_irq_in(firq_in),
        .ctrl_out(ctrl), .tx_status_full_irq_out(firq_out), .irq_out(irq));
    mfcfg_far_model u_mfcfg_far_model (.clk_in(clk), .rst_in(rst), .run_in(ctrl.tx_run), .full_req_in(full_req),
        .active_out(act), .full_out(tsf), .full_irq_out(firq_in));
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    task summarize;
        $display("checks=%0d mismatches=%0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask : summarize
    always @(posedge clk) begin
        cyc++;
        if (cyc == 4000) begin
            mismatches++;
            summarize();
        end
    end
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1; pen <= 1'b0; pwr <= w; paddr <= a; pwdata <= d;
        @(posedge clk);
        pen <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1) @(posedge clk);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0; pen <= 1'b0;
    endtask : apb
    task chk(input logic [31:0] g, input logic [31:0] e);
        n_checks++;
        if (g !== e) begin
            mismatches++;
            $display("BAD t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask : chk
    task rdchk(input logic [11:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        chk(rd, e);
    endtask : rdchk
    task t_reset;
        rdchk(mfcfg_pkg::ADDR_RECEIVE_CONFIGURATION, 32'h0);
        rdchk(mfcfg_pkg::ADDR_TRANSMIT_CONFIGURATION, 32'h0);
        chk(32'(irq), 32'h0);
        chk(32'(pready), 32'h1);
    endtask : t_reset
    task t_flush;
        apb(1'b1, mfcfg_pkg::ADDR_RECEIVE_CONFIGURATION, 32'h0000_8000);
        rdchk(mfcfg_pkg::ADDR_RECEIVE_CONFIGURATION, 32'h0);
        apb(1'b1, mfcfg_pkg::ADDR_TRANSMIT_CONFIGURATION, 32'h0000_C000);
        rdchk(mfcfg_pkg::ADDR_TRANSMIT_CONFIGURATION, 32'h0);
        rdchk(mfcfg_pkg::ADDR_IRQ_STATUS, 32'h7);
        apb(1'b1, mfcfg_pkg::ADDR_IRQ_CLEAR, 32'hF);
        rdchk(mfcfg_pkg::ADDR_IRQ_STATUS, 32'h0);
    endtask : t_flush
    task t_rxcfg;
        logic [5:0] bytes [4];
        logic [31:0] v;
        bytes = '{6'h04, 6'h10, 6'h20, 6'h04};
        // Receiver is idle here, so the low pad bits may be changed freely.
        for (int c = 0; c < 4; c++) begin
            v = {c[1:0], 17'h0, {5{c[0]}}, 8'h0};
            apb(1'b1, mfcfg_pkg::ADDR_RECEIVE_CONFIGURATION, v);
            rdchk(mfcfg_pkg::ADDR_RECEIVE_CONFIGURATION, v);
            chk(32'(ctrl.rx_end_align_bytes), 32'(bytes[c]));
            chk(32'(ctrl.rx_end_align_bad), 32'(c == 3));
            chk(32'(ctrl.rx_lead_pad_bytes), {27'h0, {5{c[0]}}});
        end
        apb(1'b1, mfcfg_pkg::ADDR_RECEIVE_CONFIGURATION, 32'hFFFF_7FFF);
        rdchk(mfcfg_pkg::ADDR_RECEIVE_CONFIGURATION, 32'hC000_1F00);
        apb(1'b1, mfcfg_pkg::ADDR_TRANSMIT_CONFIGURATION, 32'hFFFF_3FFC);
        rdchk(mfcfg_pkg::ADDR_TRANSMIT_CONFIGURATION, 32'h4);
    endtask : t_rxcfg
    task t_tx;
        apb(1'b1, mfcfg_pkg::ADDR_IRQ_ENABLE, 32'h8);
        apb(1'b1, mfcfg_pkg::ADDR_TRANSMIT_CONFIGURATION, 32'h2);
        @(posedge clk) full_req <= 1'b1;
        @(negedge clk) chk(32'(ctrl.tx_run), 32'h0);
        apb(1'b1, mfcfg_pkg::ADDR_TRANSMIT_CONFIGURATION, 32'h6);
        @(negedge clk) chk(32'(ctrl.tx_run), 32'h1);
        chk(32'(firq_out), 32'h1);
        @(posedge clk) full_req <= 1'b0;
        // Aligning on a frame start leaves the whole frame to probe the pending stop.
        while (act === 1'b1) @(posedge clk);
        while (act !== 1'b1) @(posedge clk);
        apb(1'b1, mfcfg_pkg::ADDR_TRANSMIT_CONFIGURATION, 32'h7);
        apb(1'b1, mfcfg_pkg::ADDR_TRANSMIT_CONFIGURATION, 32'h6);
        rdchk(mfcfg_pkg::ADDR_TRANSMIT_CONFIGURATION, 32'h7);
        chk(32'(ctrl.tx_run), 32'h1);
        while (irq !== 1'b1) @(posedge clk);
        rdchk(mfcfg_pkg::ADDR_TRANSMIT_CONFIGURATION, 32'h4);
        chk(32'(ctrl.tx_run), 32'h0);
        rdchk(mfcfg_pkg::ADDR_IRQ_STATUS, 32'h8);
        apb(1'b1, mfcfg_pkg::ADDR_IRQ_CLEAR, 32'h8);
        rdchk(mfcfg_pkg::ADDR_IRQ_STATUS, 32'h0);
        chk(32'(irq), 32'h0);
        rdchk(12'h0FC, 32'h0);
        chk(32'(er), 32'h1);
    endtask : t_tx
    initial begin
        rst = 1'b1; psel = 1'b0; pen = 1'b0; pwr = 1'b0; paddr = 12'h000; pwdata = 32'h0;
        pstrb = 4'hF; full_req = 1'b0; mismatches = 0; n_checks = 0; cyc = 0;
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        t_reset();
        t_flush();
        t_rxcfg();
        t_tx();
        summarize();
    end
endmodule : tb
`default_nettype wire
